// ---- rpp_ctrl_model.sv ----
// Controller model that takes response characters from the formatter.
`timescale 1ns/1ps
module rpp_ctrl_model
(
  // Clock, reset and stall control.
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_stall,
  // Response characters from the device.
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_char,
  input  wire logic       i_tx_last,
  output logic            o_tx_ready
);
  logic [7:0] got_q[$];
  int         msg_done = 0;
  // Ready drops every other cycle while stalling, to test back pressure.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_tx_ready <= 1'b0;
    else
      o_tx_ready <= i_stall ? ~o_tx_ready : 1'b1;
  end
  // Bytes are kept raw; a newline code never ends a message, only the last flag does.
  always @(posedge i_clk)
  begin
    if (i_rst_n && i_tx_valid && o_tx_ready)
    begin
      got_q.push_back(i_tx_char);
      if (i_tx_last)
        msg_done++;
    end
  end
endmodule

// ---- rpp_pkg.sv ----
// Constants and types for the remote parameter parser.
// Function
// - Physical value is a number, optionally followed by multiplier, unit, or both; only V, A and S take a multiplier, and no unit may follow MA.
// - Multipliers EX PE T G MA K M U N P F give exponents 18 down to -15.
// - Units V, A, S, HZ, PCT and DEG are recognised.
// - Suffixes match in either letter case.
// - Letter U means micro.
// - MA is mega, but milliampere on a current parameter.
// - A bare number is taken in the basic unit.
// - Register values take decimal or #H, #Q, #B prefixes in any case.
// - Register values are answered as plain decimal integers.
// - Character options follow verbosity, never the header setting.
// - Numeric boolean rounds to integer; zero is off, otherwise on.
// - Boolean answers are digit 1 for on and 0 for off.
// - Strings use single or double quotes; doubled quote is one quote.
// - String answers are wrapped in double quotes.
// - Unclosed string absorbs the rest of the message without error.
// - Binary blocks are sent as hash, width digit, byte count, then bytes.
// - Commands run strictly one after another.
// - Output queries report the present output at once.
// - Condition bit 4 flags voltage transition, bit 5 current transition.
// - Falling filter sets event bit 4 when condition bit 4 falls.
// - Reading the extended event register clears it.
// - Enable mask gates events to status byte; request enable 8 selects them.
// - Out-of-range numeric value reports error 222.
package rpp_pkg;
  // ==========================================================================
  // Characters.
  localparam logic [7:0] CH_HASH  = 8'h23;
  localparam logic [7:0] CH_DQ    = 8'h22;
  localparam logic [7:0] CH_SQ    = 8'h27;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_ONE   = 8'h31;
  localparam logic [7:0] CH_CASE  = 8'h20;
  // ==========================================================================
  // Status bit positions and error codes.
  localparam int         COND_VOLT_BIT = 4;
  localparam int         COND_CURR_BIT = 5;
  localparam int         SRE_EXT_BIT   = 3;
  localparam logic [7:0] SRE_EXT_ONLY  = 8'h08;
  localparam logic [9:0] ERR_NONE      = 10'h000;
  localparam logic [9:0] ERR_RANGE     = 10'h0de;
  localparam logic [9:0] ERR_SYNTAX    = 10'h068;
  // ==========================================================================
  // Units and radixes.
  typedef enum logic [2:0] {RPP_U_NONE, RPP_U_VOLT, RPP_U_AMP, RPP_U_SEC,
                            RPP_U_HZ, RPP_U_PCT, RPP_U_DEG} rpp_unit_t;
  typedef enum logic [1:0] {RPP_R_DEC, RPP_R_HEX, RPP_R_OCT, RPP_R_BIN} rpp_radix_t;
  typedef enum logic [4:0] {RPP_S_IDLE = 5'h01, RPP_S_BODY = 5'h02, RPP_S_STR = 5'h04,
                            RPP_S_QUOT = 5'h08, RPP_S_SEND = 5'h10} rpp_state_t;
  localparam logic signed [5:0] EXP_NONE = 6'sd0;
endpackage

// ---- rpp_suffix.sv ----
// Suffix decoder for multiplier and unit text.
`timescale 1ns/1ps
module rpp_suffix
  import rpp_pkg::*;
(
  // Suffix text, up to three characters, left aligned, zero padded.
  input  wire logic [23:0]      i_text,
  input  wire logic [1:0]       i_len,
  input  wire logic             i_is_current,
  // Decoded result.
  output logic signed [5:0]     o_exp,
  output rpp_pkg::rpp_unit_t    o_unit,
  output logic                  o_bad
);
  logic [7:0] c0;
  logic [7:0] c1;
  logic [7:0] c2;
  logic [7:0] m;
  logic [7:0] u;
  logic       m_ok;

  // Upper-case each character and split multiplier from unit.
  always_comb
  begin
    c0 = (i_text[23:16] >= 8'h61) ? i_text[23:16] - CH_CASE : i_text[23:16];
    c1 = (i_text[15:8]  >= 8'h61) ? i_text[15:8]  - CH_CASE : i_text[15:8];
    c2 = (i_text[7:0]   >= 8'h61) ? i_text[7:0]   - CH_CASE : i_text[7:0];
    m = 8'h00;
    u = 8'h00;
    o_exp = EXP_NONE;
    o_unit = RPP_U_NONE;
    o_bad = 1'b0;
    m_ok = 1'b1;
    if (i_len == 2'd0)
    begin
      o_unit = RPP_U_NONE;
    end
    else if (i_len == 2'd2 && c0 == 8'h4d && c1 == 8'h41)
    begin
      // MA: mega, or milliampere on a current parameter.
      if (i_is_current)
      begin
        o_exp = -6'sd3;
        o_unit = RPP_U_AMP;
      end
      else
        o_exp = 6'sd6;
    end
    else if (i_len == 2'd3 && c0 == 8'h50 && c1 == 8'h43 && c2 == 8'h54)
      o_unit = RPP_U_PCT;
    else if (i_len == 2'd3 && c0 == 8'h44 && c1 == 8'h45 && c2 == 8'h47)
      o_unit = RPP_U_DEG;
    else if (i_len == 2'd2 && c0 == 8'h48 && c1 == 8'h5a)
      o_unit = RPP_U_HZ;
    else
    begin
      // Optional multiplier first, then optional unit.
      if (c0 == 8'h45 && c1 == 8'h58) o_exp = 6'sd18;
      else if (c0 == 8'h50 && c1 == 8'h45) o_exp = 6'sd15;
      else
      begin
        unique case (c0)
          8'h54: o_exp = 6'sd12;
          8'h47: o_exp = 6'sd9;
          8'h4b: o_exp = 6'sd3;
          8'h4d: o_exp = -6'sd3;
          8'h55: o_exp = -6'sd6;
          8'h4e: o_exp = -6'sd9;
          8'h50: o_exp = -6'sd12;
          8'h46: o_exp = -6'sd15;
          default: m_ok = 1'b0;
        endcase
      end
      if (!m_ok)
      begin
        u = c0;
        m = (i_len == 2'd1) ? 8'h00 : 8'hff;
      end
      else if (o_exp == 6'sd18 || o_exp == 6'sd15)
      begin
        u = c2;
        m = (i_len == 2'd3) ? 8'h00 : ((i_len == 2'd2) ? 8'h01 : 8'hff);
      end
      else
      begin
        u = c1;
        m = (i_len == 2'd2) ? 8'h00 : ((i_len == 2'd1) ? 8'h01 : 8'hff);
      end
      if (m == 8'h00)
      begin
        unique case (u)
          8'h56: o_unit = RPP_U_VOLT;
          8'h41: o_unit = RPP_U_AMP;
          8'h53: o_unit = RPP_U_SEC;
          default: o_bad = 1'b1;
        endcase
      end
      else if (m == 8'hff)
        o_bad = 1'b1;
    end
  end
endmodule

// ---- rpp_top.sv ----
// Parameter parser, response formatter and status event logic.
`timescale 1ns/1ps
module rpp_top
  import rpp_pkg::*;
#(
  parameter int MAX_VAL = 1000000
)
(
  // Clock and reset.
  input  wire logic               i_clk,
  input  wire logic               i_rst_n,
  // Incoming parameter characters.
  input  wire logic               i_rx_valid,
  input  wire logic [7:0]         i_rx_char,
  input  wire logic               i_rx_end,
  input  wire logic [1:0]         i_kind,
  input  wire logic               i_is_current,
  // Parsed value result.
  output logic                    o_val_valid,
  output logic [31:0]             o_val_mant,
  output logic signed [5:0]       o_val_exp,
  output rpp_pkg::rpp_unit_t      o_val_unit,
  output logic                    o_bool,
  output logic                    o_str_valid,
  output logic [7:0]              o_str_char,
  output logic [9:0]              o_err_code,
  output logic                    o_err_valid,
  // Command sequencing.
  input  wire logic               i_cmd_start,
  input  wire logic               i_cmd_done,
  output logic                    o_cmd_go,
  output logic                    o_cmd_busy,
  // Response formatter.
  input  wire logic               i_rsp_req,
  input  wire logic [1:0]         i_rsp_kind,
  input  wire logic [31:0]        i_rsp_value,
  input  wire logic               i_full_spelling_select,
  input  wire logic [3:0]         i_opt_short_len,
  input  wire logic [3:0]         i_opt_full_len,
  input  wire logic [7:0]         i_tx_char_in,
  output logic                    o_tx_index_next,
  input  wire logic               i_tx_ready,
  output logic                    o_tx_valid,
  output logic [7:0]              o_tx_char,
  output logic                    o_tx_last,
  // Status registers.
  input  wire logic               i_volt_moving,
  input  wire logic               i_curr_moving,
  input  wire logic               i_transition_filter_select,
  input  wire logic [15:0]        i_ext_event_enable_mask,
  input  wire logic [7:0]         i_sre,
  input  wire logic               i_ext_event_register_read,
  output logic [15:0]             o_cond,
  output logic [15:0]             o_ext_event,
  output logic                    o_srq
);
  import rpp_pkg::*;

  // ==========================================================================
  // Pin synchronisers for transition levels.
  logic [2:0] vs;
  logic [2:0] cs;
  logic       volt_st;
  logic       curr_st;
  logic       volt_prev;

  // Three-stage capture; a change counts when stages two and three agree.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      vs <= 3'h0;
      cs <= 3'h0;
      volt_st <= 1'b0;
      curr_st <= 1'b0;
    end
    else
    begin
      vs <= {vs[1:0], i_volt_moving};
      cs <= {cs[1:0], i_curr_moving};
      if (vs[1] == vs[2]) volt_st <= vs[2];
      if (cs[1] == cs[2]) curr_st <= cs[2];
    end
  end

  // ==========================================================================
  // Condition register, event register and service request.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_cond <= 16'h0000;
      volt_prev <= 1'b0;
      o_ext_event <= 16'h0000;
      o_srq <= 1'b0;
    end
    else
    begin
      o_cond <= 16'h0000;
      o_cond[COND_VOLT_BIT] <= volt_st;
      o_cond[COND_CURR_BIT] <= curr_st;
      volt_prev <= volt_st;
      // A new event in the read cycle survives the clear.
      if (i_ext_event_register_read)
        o_ext_event <= 16'h0000;
      if (i_transition_filter_select && volt_prev && !volt_st)
        o_ext_event[COND_VOLT_BIT] <= 1'b1;
      o_srq <= i_sre[SRE_EXT_BIT] && |(o_ext_event & i_ext_event_enable_mask);
    end
  end

  // ==========================================================================
  // Sequential command gating.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_cmd_busy <= 1'b0;
      o_cmd_go <= 1'b0;
    end
    else
    begin
      o_cmd_go <= 1'b0;
      if (o_cmd_busy && i_cmd_done)
        o_cmd_busy <= 1'b0;
      else if (!o_cmd_busy && i_cmd_start)
      begin
        o_cmd_busy <= 1'b1;
        o_cmd_go <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Input parser.
  rpp_state_t  st;
  rpp_radix_t  radix;
  logic [31:0] mant;
  logic        fin;
  logic        in_frac;
  logic        seen_dot;
  logic        round_up;
  logic        prefix;
  logic [7:0]  quote;
  logic [23:0] sfx;
  logic [1:0]  sfx_len;
  logic        sfx_over;
  logic [7:0]  uc;
  logic [3:0]  dig;
  logic        dig_ok;
  logic signed [5:0] s_exp;
  rpp_unit_t   s_unit;
  logic        s_bad;

  rpp_suffix u_suffix
  (
    .i_text       (sfx),
    .i_len        (sfx_len),
    .i_is_current (i_is_current),
    .o_exp        (s_exp),
    .o_unit       (s_unit),
    .o_bad        (s_bad)
  );

  // Digit value for the current radix, case folded.
  always_comb
  begin
    uc = (i_rx_char >= 8'h61) ? i_rx_char - CH_CASE : i_rx_char;
    dig = 4'h0;
    dig_ok = 1'b0;
    if (uc >= 8'h30 && uc <= 8'h39)
    begin
      dig = 4'(uc - CH_ZERO);
      dig_ok = (radix == RPP_R_HEX) || (radix == RPP_R_DEC) ||
               (radix == RPP_R_OCT && uc <= 8'h37) || (radix == RPP_R_BIN && uc <= CH_ONE);
    end
    else if (radix == RPP_R_HEX && uc >= 8'h41 && uc <= 8'h46)
    begin
      dig = 4'(uc - 8'h37);
      dig_ok = 1'b1;
    end
  end

  // Character stream state machine.
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= RPP_S_IDLE;
      radix <= RPP_R_DEC;
      mant <= 32'h0;
      in_frac <= 1'b0;
      seen_dot <= 1'b0;
      round_up <= 1'b0;
      prefix <= 1'b0;
      quote <= 8'h00;
      sfx <= 24'h0;
      sfx_len <= 2'd0;
      sfx_over <= 1'b0;
      fin <= 1'b0;
      o_val_valid <= 1'b0;
      o_val_mant <= 32'h0;
      o_val_exp <= EXP_NONE;
      o_val_unit <= RPP_U_NONE;
      o_bool <= 1'b0;
      o_str_valid <= 1'b0;
      o_str_char <= 8'h00;
      o_err_code <= ERR_NONE;
      o_err_valid <= 1'b0;
    end
    else
    begin
      o_val_valid <= 1'b0;
      o_str_valid <= 1'b0;
      o_err_valid <= 1'b0;
      unique case (st)
        RPP_S_IDLE, RPP_S_BODY:
        begin
          // The result goes out the cycle after the last character, once that character is folded in.
          // A character offered in that cycle is not taken.
          if (fin)
          begin
            fin <= 1'b0;
            st <= RPP_S_IDLE;
            o_val_valid <= 1'b1;
            o_val_mant <= mant;
            o_val_exp <= s_exp;
            o_val_unit <= s_unit;
            o_bool <= (mant != 32'h0) || round_up;
            if (s_bad || sfx_over)
            begin
              o_err_code <= ERR_SYNTAX;
              o_err_valid <= 1'b1;
            end
            else if (mant > 32'(MAX_VAL))
            begin
              o_err_code <= ERR_RANGE;
              o_err_valid <= 1'b1;
            end
            mant <= 32'h0;
            radix <= RPP_R_DEC;
            in_frac <= 1'b0;
            seen_dot <= 1'b0;
            round_up <= 1'b0;
            prefix <= 1'b0;
            sfx <= 24'h0;
            sfx_len <= 2'd0;
            sfx_over <= 1'b0;
          end
          else if (i_rx_valid && st == RPP_S_IDLE && i_kind == 2'd3 &&
                   (i_rx_char == CH_DQ || i_rx_char == CH_SQ))
          begin
            quote <= i_rx_char;
            st <= RPP_S_STR;
          end
          else if (i_rx_valid)
          begin
            st <= RPP_S_BODY;
            fin <= i_rx_end;
            if (i_rx_char == CH_HASH && st == RPP_S_IDLE)
              prefix <= 1'b1;
            else if (prefix)
            begin
              prefix <= 1'b0;
              radix <= (uc == 8'h48) ? RPP_R_HEX : ((uc == 8'h51) ? RPP_R_OCT : RPP_R_BIN);
            end
            else if (i_rx_char == 8'h2e)
            begin
              in_frac <= 1'b1;
              seen_dot <= 1'b0;
            end
            else if (dig_ok && sfx_len == 2'd0 && !in_frac)
            begin
              unique case (radix)
                RPP_R_HEX: mant <= {mant[27:0], dig};
                RPP_R_OCT: mant <= {mant[28:0], dig[2:0]};
                RPP_R_BIN: mant <= {mant[30:0], dig[0]};
                default:   mant <= 32'(mant * 32'd10 + 32'(dig));
              endcase
            end
            else if (dig_ok && in_frac && !seen_dot)
            begin
              // First fraction digit decides rounding of booleans.
              seen_dot <= 1'b1;
              round_up <= (dig >= 4'd5);
            end
            else if (!dig_ok)
            begin
              if (sfx_len == 2'd3) sfx_over <= 1'b1;
              else
              begin
                sfx <= sfx | (24'(i_rx_char) << (5'd16 - {sfx_len, 3'b000}));
                sfx_len <= sfx_len + 2'd1;
              end
            end
          end
        end
        RPP_S_STR:
        begin
          // No closing quote: the rest of the message stays in the string.
          if (i_rx_valid && i_rx_char == quote)
            st <= i_rx_end ? RPP_S_IDLE : RPP_S_QUOT;
          else if (i_rx_valid)
          begin
            o_str_valid <= 1'b1;
            o_str_char <= i_rx_char;
            if (i_rx_end) st <= RPP_S_IDLE;
          end
        end
        RPP_S_QUOT:
        begin
          if (i_rx_valid && i_rx_char == quote)
          begin
            o_str_valid <= 1'b1;
            o_str_char <= quote;
            st <= i_rx_end ? RPP_S_IDLE : RPP_S_STR;
          end
          else if (i_rx_valid)
            st <= RPP_S_IDLE;
        end
        default: st <= RPP_S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Response formatter: 0 register/decimal, 1 boolean, 2 string, 3 block.
  logic [31:0] rem;
  logic [31:0] pow;
  logic [3:0]  cnt;
  logic [3:0]  blk_digits;
  logic [1:0]  rkind;
  logic [3:0]  phase;
  logic [3:0]  opt_len;
  logic [31:0] left;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_tx_valid <= 1'b0;
      o_tx_char <= 8'h00;
      o_tx_last <= 1'b0;
      o_tx_index_next <= 1'b0;
      rem <= 32'h0;
      pow <= 32'h0;
      cnt <= 4'h0;
      blk_digits <= 4'h0;
      rkind <= 2'd0;
      phase <= 4'h0;
      opt_len <= 4'h0;
      left <= 32'h0;
    end
    else
    begin
      o_tx_index_next <= 1'b0;
      if (o_tx_valid && !i_tx_ready)
        o_tx_valid <= 1'b1;
      else if (phase == 4'h0)
      begin
        o_tx_valid <= 1'b0;
        o_tx_last <= 1'b0;
        if (i_rsp_req)
        begin
          rkind <= i_rsp_kind;
          // The value goes out as given, even while the output is still settling.
          rem <= i_rsp_value;
          left <= i_rsp_value;
          pow <= 32'd1000000000;
          cnt <= 4'd10;
          // Option text length follows verbosity only.
          opt_len <= i_full_spelling_select ? i_opt_full_len : i_opt_short_len;
          blk_digits <= 4'd8;
          phase <= (i_rsp_kind == 2'd2 || i_rsp_kind == 2'd3) ? 4'h1 : 4'h3;
        end
      end
      else if (phase == 4'h1)
      begin
        o_tx_valid <= 1'b1;
        o_tx_char <= (rkind == 2'd2) ? CH_DQ : CH_HASH;
        phase <= (rkind == 2'd2) ? 4'h5 : 4'h2;
      end
      else if (phase == 4'h2)
      begin
        o_tx_valid <= 1'b1;
        o_tx_char <= CH_ZERO + 8'(blk_digits);
        cnt <= 4'd8;
        pow <= 32'd10000000;
        phase <= 4'h4;
      end
      else if (phase == 4'h3 || phase == 4'h4)
      begin
        // Decimal digits, leading zeros kept only for block counts.
        o_tx_valid <= (left >= pow) || phase == 4'h4 || cnt == 4'd1 || rkind == 2'd1;
        o_tx_char <= (rkind == 2'd1) ? ((rem != 32'h0) ? CH_ONE : CH_ZERO)
                                     : CH_ZERO + 8'(rem / pow);
        if (rkind == 2'd1 || cnt == 4'd1)
        begin
          // An empty block ends with its count.
          o_tx_last <= (phase == 4'h3) || left == 32'h0;
          phase <= (phase == 4'h3 || left == 32'h0) ? 4'h0 : 4'h5;
        end
        else
        begin
          if (phase == 4'h3 && rem < pow) phase <= 4'h3;
          else phase <= phase;
          rem <= rem % pow;
          pow <= pow / 32'd10;
          cnt <= cnt - 4'd1;
        end
      end
      else
      begin
        // Payload characters from the caller, string or block body.
        o_tx_valid <= 1'b1;
        o_tx_char <= i_tx_char_in;
        o_tx_index_next <= 1'b1;
        opt_len <= opt_len - 4'd1;
        left <= left - 32'd1;
        if (opt_len == 4'h0 && rkind == 2'd2)
        begin
          o_tx_char <= CH_DQ;
          o_tx_last <= 1'b1;
          phase <= 4'h0;
        end
        else if (left <= 32'd1 && rkind == 2'd3)
        begin
          o_tx_last <= 1'b1;
          phase <= 4'h0;
        end
      end
    end
  end

  // ==========================================================================
  // Checks.
  AST_COND_VOLT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_cond[COND_VOLT_BIT] == $past(volt_st)) else $error("voltage condition bit wrong");
  AST_COND_CURR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_cond[COND_CURR_BIT] == $past(curr_st)) else $error("current condition bit wrong");
  sequence fall_seq;
    i_transition_filter_select && volt_prev && !volt_st;
  endsequence
  AST_FALL_EVENT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    fall_seq |=> o_ext_event[COND_VOLT_BIT]) else $error("falling event lost");
  AST_READ_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    i_ext_event_register_read && !fall_seq |=> o_ext_event == 16'h0000) else $error("event not cleared");
  AST_SRQ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    !i_sre[SRE_EXT_BIT] |=> !o_srq) else $error("request without enable");
  AST_SEQ_CMD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_cmd_busy && !i_cmd_done |=> !o_cmd_go) else $error("command overlapped");
  AST_GO_BUSY: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_cmd_go |-> o_cmd_busy) else $error("go without busy");
  AST_BOOL_CHAR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    o_tx_valid && rkind == 2'd1 && phase == 4'h0 |-> o_tx_char == CH_ONE || o_tx_char == CH_ZERO)
    else $error("boolean answer not a digit");
endmodule

// ---- tb_top.sv ----
// Self-checking testbench for the remote parameter parser.
`timescale 1ns/1ps
module tb_top;
  import rpp_pkg::*;
  // ==========================================================================
  // Stimulus, design outputs and bookkeeping.
  logic        clk, rst_n, rv, re, cur, cs, cd, rq, fs, vmv, cmv, flt, rrd, stall;
  logic [7:0]  rc, tci, sre, sc, tch;
  logic [1:0]  kd, rk;
  logic [31:0] rval, vmn, vm;
  logic [15:0] msk, cnd, eev;
  logic [9:0]  ecd, ec;
  logic        vv, bl, sv, ev, go, busy, tin, tv, tl, rdy, srq, vb;
  logic signed [5:0] vex, ve;
  rpp_unit_t   vun, vu;
  logic [7:0]  sq[$];
  int          bad_count = 0, checks = 0, vn = 0, en = 0, n0, n1, ti = 0;
  string       mt[11] = '{"EX", "PE", "T", "G", "MA", "K", "M", "U", "N", "P", "F"};
  string       ut[6] = '{"V", "A", "S", "HZ", "PCT", "DEG"};
  string       rs[4] = '{"#h1F", "#Q17", "#b101", "25"};
  int          rx[4] = '{31, 15, 5, 25};
  string       bs[3] = '{"0.4", "0.6", "3"};
  rpp_top #(.MAX_VAL(1000000)) DUT (.i_clk(clk), .i_rst_n(rst_n), .i_rx_valid(rv), .i_rx_char(rc),
    .i_rx_end(re), .i_kind(kd), .i_is_current(cur), .o_val_valid(vv), .o_val_mant(vmn), .o_val_exp(vex),
    .o_val_unit(vun), .o_bool(bl), .o_str_valid(sv), .o_str_char(sc), .o_err_code(ecd), .o_err_valid(ev),
    .i_cmd_start(cs), .i_cmd_done(cd), .o_cmd_go(go), .o_cmd_busy(busy), .i_rsp_req(rq), .i_rsp_kind(rk),
    .i_rsp_value(rval), .i_full_spelling_select(fs), .i_opt_short_len(4'h3), .i_opt_full_len(4'h7),
    .i_tx_char_in(tci), .o_tx_index_next(tin), .i_tx_ready(rdy), .o_tx_valid(tv), .o_tx_char(tch),
    .o_tx_last(tl), .i_volt_moving(vmv), .i_curr_moving(cmv), .i_transition_filter_select(flt),
    .i_ext_event_enable_mask(msk), .i_sre(sre), .i_ext_event_register_read(rrd), .o_cond(cnd),
    .o_ext_event(eev), .o_srq(srq));
  rpp_ctrl_model HOST (.i_clk(clk), .i_rst_n(rst_n), .i_stall(stall), .i_tx_valid(tv), .i_tx_char(tch),
    .i_tx_last(tl), .o_tx_ready(rdy));
  // Clock at 125 MHz.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Results are captured at the edge after each one-cycle pulse.
  always @(posedge clk)
  begin
    if (vv)
    begin
      vm = vmn;
      ve = vex;
      vu = vun;
      vb = bl;
      vn++;
    end
    if (ev)
    begin
      ec = ecd;
      en++;
    end
    if (sv)
      sq.push_back(sc);
    if (tin)
      ti++;
  end
  // ==========================================================================
  // Tasks.
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    begin
      checks++;
      if (seen !== exp)
      begin
        bad_count++;
        $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task automatic test_done;
    if (bad_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic send(string s, logic [1:0] k);
    for (int i = 0; i < s.len(); i++)
    begin
      rv = 1'b1;
      rc = s[i];
      kd = k;
      re = (i == s.len() - 1);
      step;
    end
    rv = 1'b0;
    re = 1'b0;
  endtask
  // Sends a parameter and waits a bounded time for a value, then checks the error count.
  task automatic parse(string s, logic [1:0] k, int e = 0);
    n0 = vn;
    n1 = en;
    send(s, k);
    for (int i = 0; i < 20 && vn == n0; i++)
      step;
    chk(32'(vn - n0), 32'h1);
    chk(32'(en - n1), 32'(e));
  endtask
  task automatic phys(string s, logic c, logic [31:0] m, int e, rpp_unit_t u);
    cur = c;
    parse(s, 2'h0);
    chk(vm, m);
    chk({26'h0, ve}, {26'h0, e[5:0]});
    chk({29'h0, vu}, {29'h0, u});
  endtask
  task automatic same(logic [7:0] q[$], string s);
    chk(32'(q.size()), 32'(s.len()));
    for (int i = 0; i < s.len(); i++)
      chk({24'h0, q[i]}, {24'h0, s[i]});
  endtask
  // Requests a response and waits for the controller to see its last byte.
  task automatic rsp(logic [1:0] k, logic [31:0] v);
    n0 = HOST.msg_done;
    HOST.got_q.delete();
    rq = 1'b1;
    rk = k;
    rval = v;
    step;
    rq = 1'b0;
    for (int i = 0; i < 300 && HOST.msg_done == n0; i++)
      step;
    chk(32'(HOST.msg_done - n0), 32'h1);
  endtask
  // ==========================================================================
  // Watchdog at 50000 cycles, well beyond the few hundred cycles that the tests need.
  initial
  begin
    #400000;
    bad_count++;
    test_done;
  end
  // Main sequence.
  initial
  begin
    {rv, re, cur, cs, cd, rq, fs, vmv, cmv, flt, rrd, stall} = '0;
    {rc, sre, kd, rk, rval, msk} = '0;
    tci = 8'h0a;
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    phys("5MV", 1'b0, 5, -3, RPP_U_VOLT);
    for (int i = 0; i < 11; i++)
      phys({"7", mt[i]}, 1'b0, 7, (i < 6) ? 18 - 3 * i : 15 - 3 * i, RPP_U_NONE);
    for (int i = 0; i < 6; i++)
      phys({"3", ut[i]}, 1'b0, 3, 0, rpp_unit_t'(i + 1));
    phys("7kv", 1'b0, 7, 3, RPP_U_VOLT);
    phys("7u", 1'b0, 7, -6, RPP_U_NONE);
    phys("7ma", 1'b1, 7, -3, RPP_U_AMP);
    phys("7", 1'b0, 7, 0, RPP_U_NONE);
    for (int i = 0; i < 4; i++)
    begin
      parse(rs[i], 2'h1);
      chk(vm, 32'(rx[i]));
    end
    for (int i = 0; i < 3; i++)
    begin
      parse(bs[i], 2'h2);
      chk({31'h0, vb}, {31'h0, i > 0});
    end
    parse("7XQ", 2'h0, 1);
    chk({22'h0, ec}, {22'h0, ERR_SYNTAX});
    parse("2000000", 2'h0, 1);
    chk({22'h0, ec}, {22'h0, ERR_RANGE});
    sq.delete();
    send("'a''b'", 2'h3);
    repeat (4) step;
    same(sq, "a'b");
    sq.delete();
    n0 = en;
    send("\"xy", 2'h3);
    repeat (4) step;
    same(sq, "xy");
    chk(32'(en - n0), 32'h0);
    stall = 1'b1;
    rsp(2'h0, 32'd123);
    same(HOST.got_q, "123");
    rsp(2'h1, 32'h1);
    same(HOST.got_q, "1");
    rsp(2'h1, 32'h0);
    same(HOST.got_q, "0");
    rsp(2'h2, 32'h2);
    chk({24'h0, HOST.got_q[0]}, {24'h0, CH_DQ});
    chk({24'h0, HOST.got_q[$]}, {24'h0, CH_DQ});
    same(HOST.got_q, "\"\n\n\n\"");
    fs = 1'b1;
    rsp(2'h2, 32'h2);
    chk(32'(HOST.got_q.size()), 32'd9);
    n1 = ti;
    rsp(2'h3, 32'h2);
    chk({24'h0, HOST.got_q[0]}, {24'h0, CH_HASH});
    chk({24'h0, HOST.got_q[$]}, 32'h0a);
    same(HOST.got_q, "#800000002\n\n");
    chk(32'(ti - n1), 32'd2);
    cs = 1'b1;
    step;
    cs = 1'b0;
    chk({30'h0, go, busy}, 32'h3);
    step;
    cs = 1'b1;
    step;
    cs = 1'b0;
    chk({30'h0, go, busy}, 32'h1);
    cd = 1'b1;
    step;
    cd = 1'b0;
    step;
    chk({31'h0, busy}, 32'h0);
    flt = 1'b1;
    msk = 16'h0010;
    sre = SRE_EXT_ONLY;
    vmv = 1'b1;
    cmv = 1'b1;
    repeat (6) step;
    chk({16'h0, cnd & 16'h0030}, 32'h30);
    vmv = 1'b0;
    cmv = 1'b0;
    repeat (6) step;
    chk({16'h0, cnd & 16'h0030}, 32'h0);
    chk({30'h0, eev[4], srq}, 32'h3);
    rrd = 1'b1;
    step;
    rrd = 1'b0;
    repeat (2) step;
    chk({30'h0, eev[4], srq}, 32'h0);
    msk = 16'h0000;
    vmv = 1'b1;
    repeat (6) step;
    rsp(2'h0, 32'd103);
    same(HOST.got_q, "103");
    chk({31'h0, cnd[4]}, 32'h1);
    vmv = 1'b0;
    repeat (6) step;
    chk({30'h0, eev[4], srq}, 32'h2);
    test_done;
  end
endmodule
